/* design/motion_switch_pkg.sv */
`default_nettype none
package motion_switch_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 40_000_000;
    localparam int ZC_TIMEOUT_MS = 40;
    localparam int ZC_TIMEOUT_CYC = (CLK_HZ / 1000) * ZC_TIMEOUT_MS;
    localparam int NO_MOTION_S = 30;
    localparam int NO_MOTION_CYC = CLK_HZ * NO_MOTION_S;
    // ****************************************
    // Event counts
    // ****************************************
    localparam int ACQ_EDGES = 3;
    localparam int START_CROSSINGS = 2;
    localparam int OVER_SAMPLES = 8;
    localparam int UNDER_WINDOWS = 4;
    localparam int RETRY_CLEAR_HALF = 10;
    localparam int RETRY_MAX_DEF = 3;
    // ****************************************
    // Widths
    // ****************************************
    localparam int MEAS_W = 24;
    localparam int RETRY_W = 4;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int LEVEL_W = 12;
    localparam int EV_W = 5;
    // ****************************************
    // Register map and fields
    // ****************************************
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_MIN = 4'h1;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h2;
    localparam logic [ADDR_W-1:0] REG_EVENT = 4'h3;
    localparam logic [ADDR_W-1:0] REG_RETRY = 4'h4;
    localparam logic [ADDR_W-1:0] REG_PERIOD = 4'h5;
    localparam logic [ADDR_W-1:0] REG_RELOAD = 4'h6;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam logic [LEVEL_W-1:0] MIN_RST = 12'h0e0;
    localparam int EV_VOLT_TO = 0;
    localparam int EV_CUR_TO = 1;
    localparam int EV_OVER = 2;
    localparam int EV_UNDER = 3;
    localparam int EV_NO_MOTION = 4;
    localparam int STAT_STATE = 0;
    localparam int STAT_PEND = 2;
    localparam int STAT_OK = 3;
    localparam int STAT_MOTION = 4;
    typedef enum logic [1:0] {
        S_OFF, S_VOLT_ACQ, S_CURRENT_ZERO, S_ON
    } switch_state_e;
endpackage
`default_nettype wire

/* design/motion_ac_switch_event_fsm.sv */
// How it works
// [RULE1] Acquisition times intervals across three mains edges for period and zero.
// [RULE2] Acquisition end fires the first trigger pulse, switching the load on.
// [RULE3] Acquisition reacts to rising and falling mains comparator edges.
// [RULE4] Current zero indicator gives edges and gates the placement counter.
// [RULE5] In ON, low time of indicator schedules the next trigger pulse.
// [RULE6] Overcurrent rising edge latches a pending bit, no interrupt.
// [RULE7] Pending bit sampled each half-cycle; eight in a row is over-maximum.
// [RULE8] Peak level below threshold in four windows running is under-minimum.
// [RULE9] In ON, current is fine while between minimum and maximum.
// [RULE10] A 40 ms one-shot timeout runs in acquisition and ON.
// [RULE11] Finishing the period estimate restarts the 40 ms timeout.
// [RULE12] Each indicator rising edge restarts the timeout in current phase.
// [RULE13] Timeout expiry flags the timeout and counts a retry.
// [RULE14] Retry count clears ten half-cycles after entering ON.
// [RULE15] Acquisition timeout retries below maximum, else goes OFF.
// [RULE16] Current-phase timeout goes straight to OFF.
// [RULE17] Motion moves OFF to acquisition, or keeps ON.
// [RULE18] Motion seen restarts the 30 s no-motion timer.
// [RULE19] No motion for 30 s in ON goes to OFF.
// [RULE20] No-motion timeout disables the placement timer, ending pulses.
// [RULE21] Motion input is active low and synchronised first.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`default_nettype none
module motion_ac_switch_event_fsm
    import motion_switch_pkg::*;
#(
    parameter int TIMEOUT_CYC = ZC_TIMEOUT_CYC,
    parameter int NO_MOTION_CYC_P = NO_MOTION_CYC,
    parameter logic [RETRY_W-1:0] RETRY_MAX = RETRY_W'(RETRY_MAX_DEF)
) (
    input wire logic CLOCK_IN,
    input wire logic RST_IN,
    input wire logic [ADDR_W-1:0] ADDR_IN,
    input wire logic [DATA_W-1:0] WR_DATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [DATA_W-1:0] RD_DATA_OUT,
    input wire logic MAINS_COMPARATOR_OUTPUT_IN,
    input wire logic CURRENT_ZERO_INDICATOR_IN,
    input wire logic OVERCURRENT_FLAG_IN,
    input wire logic MOTION_DETECT_N_IN,
    input wire logic [LEVEL_W-1:0] CURRENT_SENSE_LEVEL_IN,
    output logic SCR_TRIGGER_OUT,
    output logic PLACE_TIMER_EN_OUT,
    output logic [MEAS_W-1:0] TIMER_RELOAD_OUT
);
    localparam int TO_W = $clog2(TIMEOUT_CYC + 1);
    localparam int NM_W = $clog2(NO_MOTION_CYC_P + 1);

    switch_state_e state, next_state;
    logic [3:0] sync1, sync2, prev;
    logic mains_s, cz_s, oc_s, motion;
    logic v_edge, i_rise, i_fall, oc_rise;
    logic ctrl_en;
    logic [LEVEL_W-1:0] min_thresh;
    logic [EV_W-1:0] events, ev_set;
    logic [TO_W-1:0] to_cnt;
    logic to_run, to_expire, restart_to;
    logic voltage_acquire_timeout, current_zero_timeout, no_motion_timeout;
    logic [RETRY_W-1:0] retry;
    logic [3:0] on_half;
    logic [1:0] acq_edges, start_cnt;
    logic [MEAS_W-1:0] t_cnt, int1, period, low_cnt, hi_cnt, hi_len, reload;
    logic acq_start, acq_third, first_fire, ac_live, on_tick;
    logic oc_pend, oc_seen, above;
    logic [3:0] oc_run, under_run;
    logic over_max, under_min, peak_hit;
    logic [NM_W-1:0] nm_cnt;

    // ****************************************
    // Input synchronisers
    // ****************************************
    // Two stages, third holds last value for edges
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            sync1 <= 4'hf;
            sync2 <= 4'hf;
            prev <= 4'hf;
        end else begin
            sync1 <= {MOTION_DETECT_N_IN, OVERCURRENT_FLAG_IN,
                      CURRENT_ZERO_INDICATOR_IN, MAINS_COMPARATOR_OUTPUT_IN};
            sync2 <= sync1;
            prev <= sync2;
        end
    end

    // Edge events from synchronised levels
    assign mains_s = sync2[0];
    assign cz_s = sync2[1];
    assign oc_s = sync2[2];
    // [RULE21] Active low motion
    assign motion = ~sync2[3];
    // [RULE3] Both mains edges
    assign v_edge = mains_s ^ prev[0];
    // [RULE4] Indicator edge events
    assign i_rise = cz_s & ~prev[1];
    assign i_fall = ~cz_s & prev[1];
    assign oc_rise = oc_s & ~prev[2];

    // ****************************************
    // Event decode
    // ****************************************
    // Timeouts, half-cycle ticks and limit events
    assign to_expire = to_run && (to_cnt == TO_W'(TIMEOUT_CYC - 1));
    assign voltage_acquire_timeout = to_expire && (state == S_VOLT_ACQ);
    assign ac_live = (state == S_CURRENT_ZERO) || (state == S_ON);
    assign current_zero_timeout = to_expire && ac_live;
    assign on_tick = (state == S_ON) && i_rise;
    assign oc_seen = oc_pend | oc_rise;
    // [RULE7] Eighth overload sample
    assign over_max = on_tick && oc_seen && (oc_run == 4'(OVER_SAMPLES - 1));
    // [RULE8] Fourth low window
    assign under_min = on_tick && !above && (under_run == 4'(UNDER_WINDOWS - 1));
    // [RULE19] No-motion expiry in ON
    assign no_motion_timeout = (state == S_ON) &&
                               (nm_cnt == NM_W'(NO_MOTION_CYC_P - 1));
    assign acq_third = (state == S_VOLT_ACQ) && v_edge &&
                       (acq_edges == 2'(ACQ_EDGES - 1));
    // [RULE2] First pulse at predicted zero
    assign first_fire = (state == S_VOLT_ACQ) && !to_expire &&
                        (acq_edges == 2'(ACQ_EDGES)) && (t_cnt == int1);
    assign acq_start = (next_state == S_VOLT_ACQ) &&
                       ((state != S_VOLT_ACQ) || to_expire);
    // [RULE11] Restart after estimate
    // [RULE12] Restart on indicator rise
    assign restart_to = acq_start || acq_third || (ac_live && i_rise);
    assign peak_hit = cz_s && (hi_cnt == {1'b0, hi_len[MEAS_W-1:1]});

    // ****************************************
    // State machine
    // ****************************************
    // Next state from events
    always_comb begin
        next_state = state;
        case (state)
            S_OFF: begin
                // [RULE17] Motion starts acquisition
                if (motion && ctrl_en) begin
                    next_state = S_VOLT_ACQ;
                end
            end
            S_VOLT_ACQ: begin
                // [RULE15] Retry or give up
                if (voltage_acquire_timeout) begin
                    next_state = (retry < RETRY_MAX) ? S_VOLT_ACQ : S_OFF;
                end else if (!ctrl_en) begin
                    next_state = S_OFF;
                end else if (first_fire) begin
                    next_state = S_CURRENT_ZERO;
                end
            end
            S_CURRENT_ZERO: begin
                // [RULE16] No retry here
                if (current_zero_timeout || !ctrl_en) begin
                    next_state = S_OFF;
                end else if (i_rise &&
                             start_cnt == 2'(START_CROSSINGS - 1)) begin
                    next_state = S_ON;
                end
            end
            S_ON: begin
                // [RULE16] Timeout ends ON
                if (current_zero_timeout || over_max || under_min ||
                    no_motion_timeout || !ctrl_en) begin
                    next_state = S_OFF;
                end
            end
            default: begin
                next_state = S_OFF;
            end
        endcase
    end

    // State register and placement timer enable
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state <= S_OFF;
            PLACE_TIMER_EN_OUT <= 1'b0;
        end else begin
            state <= next_state;
            // [RULE20] Timer off when leaving ON
            PLACE_TIMER_EN_OUT <= (next_state == S_CURRENT_ZERO) ||
                                  (next_state == S_ON);
        end
    end

    // ****************************************
    // One-shot timeout
    // ****************************************
    // [RULE10] 40 ms one-shot
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            to_cnt <= '0;
            to_run <= 1'b0;
        end else if (next_state == S_OFF) begin
            to_cnt <= '0;
            to_run <= 1'b0;
        end else if (restart_to) begin
            to_cnt <= '0;
            to_run <= 1'b1;
        end else if (to_expire) begin
            to_run <= 1'b0;
        end else if (to_run) begin
            to_cnt <= to_cnt + 1'b1;
        end
    end

    // Retry counter and ON half-cycle count
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            retry <= '0;
            on_half <= '0;
        end else begin
            on_half <= (state != S_ON) ? 4'h0 :
                       (on_tick && on_half != 4'(RETRY_CLEAR_HALF)) ?
                       on_half + 1'b1 : on_half;
            if (state == S_OFF && next_state == S_VOLT_ACQ) begin
                retry <= '0;
            // [RULE13] Count a retry
            end else if (to_expire && state != S_OFF && retry != '1) begin
                retry <= retry + 1'b1;
            // [RULE14] Clear after ten half-cycles
            end else if (on_tick && on_half == 4'(RETRY_CLEAR_HALF - 1)) begin
                retry <= '0;
            end
        end
    end

    // ****************************************
    // Voltage acquisition
    // ****************************************
    // [RULE1] Interval timing over three edges
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            acq_edges <= '0;
            t_cnt <= '0;
            int1 <= '0;
            period <= '0;
        end else if (acq_start) begin
            acq_edges <= '0;
            t_cnt <= '0;
        end else if (state == S_VOLT_ACQ) begin
            if (v_edge && acq_edges != 2'(ACQ_EDGES)) begin
                acq_edges <= acq_edges + 1'b1;
                // Edge cycle counts as one, so an interval is edge to edge
                t_cnt <= MEAS_W'(1);
                if (acq_edges == 2'h1) begin
                    int1 <= t_cnt;
                end
                if (acq_third) begin
                    period <= int1 + t_cnt;
                end
            end else begin
                t_cnt <= t_cnt + 1'b1;
            end
        end
    end

    // ****************************************
    // Pulse placement
    // ****************************************
    // [RULE4] Counter runs only while indicator low
    // [RULE5] Low time sets next reload
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            low_cnt <= '0;
            reload <= '0;
            start_cnt <= '0;
        end else if (!ac_live) begin
            low_cnt <= '0;
            start_cnt <= '0;
        end else begin
            if (i_fall) begin
                // Falling edge cycle is the first low cycle
                low_cnt <= MEAS_W'(1);
            end else if (!cz_s) begin
                low_cnt <= low_cnt + 1'b1;
            end
            if (i_rise) begin
                reload <= {1'b0, low_cnt[MEAS_W-1:1]};
                start_cnt <= start_cnt + 1'b1;
            end
        end
    end

    // Trigger pulse and reload output
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            SCR_TRIGGER_OUT <= 1'b0;
            TIMER_RELOAD_OUT <= '0;
        end else begin
            SCR_TRIGGER_OUT <= first_fire || (PLACE_TIMER_EN_OUT && ac_live &&
                               !cz_s && !i_fall && low_cnt == reload);
            TIMER_RELOAD_OUT <= reload;
        end
    end

    // ****************************************
    // Load current checks
    // ****************************************
    // [RULE6] Latch overcurrent edge
    // [RULE7] Consecutive overload samples
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            oc_pend <= 1'b0;
            oc_run <= '0;
        end else begin
            oc_pend <= oc_rise || (oc_pend && !on_tick);
            if (state != S_ON) begin
                oc_run <= '0;
            end else if (on_tick) begin
                oc_run <= oc_seen ? oc_run + 1'b1 : 4'h0;
            end
        end
    end

    // [RULE8] Peak sampling per window
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            hi_cnt <= '0;
            hi_len <= '0;
            above <= 1'b0;
            under_run <= '0;
        end else begin
            hi_cnt <= (i_rise || !cz_s) ? '0 : hi_cnt + 1'b1;
            if (i_fall) begin
                hi_len <= hi_cnt;
            end
            if (state != S_ON) begin
                above <= 1'b0;
                under_run <= '0;
            end else if (on_tick) begin
                above <= 1'b0;
                under_run <= above ? 4'h0 : under_run + 1'b1;
            end else if (peak_hit && CURRENT_SENSE_LEVEL_IN >= min_thresh) begin
                above <= 1'b1;
            end
        end
    end

    // [RULE18] Motion restarts no-motion timer
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            nm_cnt <= '0;
        end else if (motion || state == S_OFF) begin
            nm_cnt <= '0;
        end else if (nm_cnt != NM_W'(NO_MOTION_CYC_P - 1)) begin
            nm_cnt <= nm_cnt + 1'b1;
        end
    end

    // ****************************************
    // Register port
    // ****************************************
    // [RULE13] Timeout flags, plus over-maximum, under-minimum and no-motion event flags
    assign ev_set = {no_motion_timeout && next_state == S_OFF, under_min,
                     over_max, current_zero_timeout, voltage_acquire_timeout};

    // Control writes and sticky events, set beats clear
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ctrl_en <= CTRL_EN_RST;
            min_thresh <= MIN_RST;
            events <= '0;
        end else begin
            if (WR_IN && ADDR_IN == REG_CTRL) begin
                ctrl_en <= WR_DATA_IN[CTRL_EN_BIT];
            end
            if (WR_IN && ADDR_IN == REG_MIN) begin
                min_thresh <= WR_DATA_IN[LEVEL_W-1:0];
            end
            if (WR_IN && ADDR_IN == REG_EVENT) begin
                events <= (events & ~WR_DATA_IN[EV_W-1:0]) | ev_set;
            end else begin
                events <= events | ev_set;
            end
        end
    end

    // Read data, valid one cycle after the strobe
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            RD_DATA_OUT <= '0;
        end else begin
            RD_DATA_OUT <= '0;
            if (RD_IN) begin
                case (ADDR_IN)
                    REG_CTRL: RD_DATA_OUT[CTRL_EN_BIT] <= ctrl_en;
                    REG_MIN: RD_DATA_OUT[LEVEL_W-1:0] <= min_thresh;
                    REG_STATUS: begin
                        RD_DATA_OUT[STAT_STATE+:2] <= state;
                        RD_DATA_OUT[STAT_PEND] <= oc_pend;
                        // [RULE9] Current within limits
                        RD_DATA_OUT[STAT_OK] <= (state == S_ON) &&
                                                oc_run == 4'h0 && under_run == 4'h0;
                        RD_DATA_OUT[STAT_MOTION] <= motion;
                    end
                    REG_EVENT: RD_DATA_OUT[EV_W-1:0] <= events;
                    REG_RETRY: RD_DATA_OUT[RETRY_W-1:0] <= retry;
                    REG_PERIOD: RD_DATA_OUT[MEAS_W-1:0] <= period;
                    REG_RELOAD: RD_DATA_OUT[MEAS_W-1:0] <= reload;
                    default: RD_DATA_OUT <= '0;
                endcase
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (RST_IN);

    sequence s_third_edge;
        acq_third ##1 (acq_edges == 2'h3 && to_cnt == '0);
    endsequence
    sequence s_nomotion_off;
        (state == S_OFF) ##1 !PLACE_TIMER_EN_OUT;
    endsequence

    edge_count_a: // [RULE1]
    assert property (acq_third && !to_expire |-> ##1 (acq_edges == 2'h3) ##0
                     (period == $past(int1) + $past(t_cnt)))
        else $error("period estimate not taken on third edge");
    timeout_restart_a: // [RULE11]
    assert property (acq_third && !to_expire && next_state != S_OFF |-> s_third_edge)
        else $error("timeout not restarted after estimate");
    first_fire_a: // [RULE2]
    assert property (first_fire && ctrl_en |=> SCR_TRIGGER_OUT && state == S_CURRENT_ZERO)
        else $error("first pulse missing after acquisition");
    oc_latch_a: // [RULE6]
    assert property (oc_rise |=> oc_pend)
        else $error("overcurrent edge not latched");
    over_max_a: // [RULE7]
    assert property (over_max |=> events[EV_OVER] && state == S_OFF)
        else $error("over-maximum not acted on");
    under_min_a: // [RULE8]
    assert property ((state == S_ON && on_tick && !above &&
                      under_run == 4'h3) |=> state == S_OFF && events[EV_UNDER])
        else $error("under-minimum not acted on");
    retry_count_a: // [RULE13]
    assert property (voltage_acquire_timeout && retry != '1 |=>
                     retry == $past(retry) + 1'b1 && events[EV_VOLT_TO])
        else $error("retry not counted on timeout");
    cur_timeout_a: // [RULE16]
    assert property (current_zero_timeout |=> state == S_OFF)
        else $error("current timeout did not switch off");
    no_motion_a: // [RULE20]
    assert property (no_motion_timeout && !motion |=> s_nomotion_off)
        else $error("no-motion timeout left pulses running");
    motion_start_a: // [RULE17]
    assert property ($fell(sync2[3]) && state == S_OFF && ctrl_en |=>
                     state == S_VOLT_ACQ)
        else $error("motion did not start acquisition");
endmodule // motion_ac_switch_event_fsm
`default_nettype wire

/* verification/mains_partner.sv */
`default_nettype none
module mains_partner (
    input wire logic clk_in,
    input wire logic mains_on_in,
    input wire logic cur_on_in,
    input wire logic over_on_in,
    output logic mains_out,
    output logic cur_zero_out,
    output logic over_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [5:0] ph = 6'h00;
    logic mains = 1'b0;
    // Phase within a 40-cycle half-cycle; comparator flips at its end
    always @(posedge clk_in) begin
        ph <= (ph == 6'h27) ? 6'h00 : ph + 6'h01;
        if (ph == 6'h27 && mains_on_in) begin
            mains <= ~mains;
        end
    end
    // Indicator low for 10 cycles per half-cycle, overload pulse mid-way
    assign mains_out = mains;
    assign cur_zero_out = !(cur_on_in && ph < 6'h0a);
    assign over_out = over_on_in && ph > 6'h14 && ph < 6'h18;
endmodule // mains_partner
`default_nettype wire

/* verification/testbench.sv */
`default_nettype none
module testbench;
    import motion_switch_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic CLOCK_IN, RST_IN, WR_IN, RD_IN, MOTION_DETECT_N_IN, SCR_TRIGGER_OUT, PLACE_TIMER_EN_OUT;
    logic [ADDR_W-1:0] ADDR_IN;
    logic [DATA_W-1:0] WR_DATA_IN, RD_DATA_OUT;
    logic [LEVEL_W-1:0] LEVEL_IN;
    logic [MEAS_W-1:0] TIMER_RELOAD_OUT;
    logic mains, cur_zero, over, mains_on, cur_on, over_on;
    int num_errors = 0;
    int compares = 0;
    int pulses = 0;
    int n;
    // ****************************************
    // Design and far side
    // ****************************************
    motion_ac_switch_event_fsm #(.TIMEOUT_CYC(200), .NO_MOTION_CYC_P(500)) dut (
        .CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN), .ADDR_IN(ADDR_IN), .WR_DATA_IN(WR_DATA_IN),
        .WR_IN(WR_IN), .RD_IN(RD_IN), .RD_DATA_OUT(RD_DATA_OUT),
        .MAINS_COMPARATOR_OUTPUT_IN(mains), .CURRENT_ZERO_INDICATOR_IN(cur_zero),
        .OVERCURRENT_FLAG_IN(over), .MOTION_DETECT_N_IN(MOTION_DETECT_N_IN),
        .CURRENT_SENSE_LEVEL_IN(LEVEL_IN), .SCR_TRIGGER_OUT(SCR_TRIGGER_OUT),
        .PLACE_TIMER_EN_OUT(PLACE_TIMER_EN_OUT), .TIMER_RELOAD_OUT(TIMER_RELOAD_OUT));
    mains_partner far (.clk_in(CLOCK_IN), .mains_on_in(mains_on), .cur_on_in(cur_on),
        .over_on_in(over_on), .mains_out(mains), .cur_zero_out(cur_zero), .over_out(over));
    // Clock and trigger pulse count
    initial begin
        CLOCK_IN = 1'b0;
        forever #12.5 CLOCK_IN = ~CLOCK_IN;
    end
    always @(posedge CLOCK_IN) if (SCR_TRIGGER_OUT === 1'b1) pulses++;
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Bus write and read
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge CLOCK_IN);
        ADDR_IN <= a;
        WR_DATA_IN <= d;
        WR_IN <= 1'b1;
        @(posedge CLOCK_IN);
        WR_IN <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge CLOCK_IN);
        ADDR_IN <= a;
        RD_IN <= 1'b1;
        @(posedge CLOCK_IN);
        RD_IN <= 1'b0;
        #1 v = RD_DATA_OUT;
    endtask
    task automatic rc(input string nm, input logic [3:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        chk(nm, e, v);
    endtask
    // Poll the state field with a bound
    task automatic wait_state(input logic [1:0] s);
        logic [31:0] v;
        for (int i = 0; i < 2000; i++) begin
            rd(REG_STATUS, v);
            if (v[1:0] === s) break;
        end
        chk("state", {30'h0, s}, {30'h0, v[1:0]});
    endtask
    // Motion held active for a few cycles
    task automatic pulse_motion();
        @(posedge CLOCK_IN);
        MOTION_DETECT_N_IN <= 1'b0;
        repeat (5) @(posedge CLOCK_IN);
        MOTION_DETECT_N_IN <= 1'b1;
    endtask
    task automatic test_done();
        if (num_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (60000) @(posedge CLOCK_IN);
        num_errors++;
        test_done();
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        RST_IN = 1'b1;
        {WR_IN, RD_IN, ADDR_IN, WR_DATA_IN} = '0;
        MOTION_DETECT_N_IN = 1'b1;
        LEVEL_IN = 12'h200;
        {mains_on, cur_on, over_on} = 3'b000;
        repeat (2) @(posedge CLOCK_IN);
        RST_IN <= 1'b0;
        rc("ctrl", REG_CTRL, 32'h1);
        rc("min", REG_MIN, 32'he0);
        rc("status", REG_STATUS, 32'h0);
        wr(4'hf, 32'hffffffff);
        rc("unmapped", 4'hf, 32'h0);
        wr(REG_CTRL, 32'h0);
        pulse_motion();
        // Still OFF while disabled; the synchroniser shows motion a little longer
        rc("status", REG_STATUS, 32'h10);
        wr(REG_CTRL, 32'h1);
        pulse_motion();
        wait_state(2'd1);
        wait_state(2'd0);
        rc("event", REG_EVENT, 32'h1);
        rc("retry", REG_RETRY, 32'h4);
        wr(REG_EVENT, 32'h1f);
        // One empty attempt first, so a retry stands when ON is reached
        MOTION_DETECT_N_IN <= 1'b0;
        repeat (220) @(posedge CLOCK_IN);
        wr(REG_EVENT, 32'h1f);
        mains_on <= 1'b1;
        cur_on <= 1'b1;
        wait_state(2'd3);
        chk("trigger", 32'h1, {31'h0, pulses != 0});
        chk("enable", 32'h1, {31'h0, PLACE_TIMER_EN_OUT});
        rc("retry", REG_RETRY, 32'h1);
        rc("period", REG_PERIOD, 32'd80);
        rc("reload", REG_RELOAD, 32'd5);
        chk("reload pin", 32'd5, {8'h0, TIMER_RELOAD_OUT});
        repeat (480) @(posedge CLOCK_IN);
        rc("status", REG_STATUS, 32'h1b);
        rc("retry", REG_RETRY, 32'h0);
        MOTION_DETECT_N_IN <= 1'b1;
        repeat (400) @(posedge CLOCK_IN);
        wait_state(2'd3);
        wait_state(2'd0);
        rc("event", REG_EVENT, 32'h10);
        n = pulses;
        repeat (200) @(posedge CLOCK_IN);
        chk("enable", 32'h0, {31'h0, PLACE_TIMER_EN_OUT});
        chk("pulses", n, pulses);
        wr(REG_EVENT, 32'h1f);
        // Overload, low current, lost current zero
        for (int k = 0; k < 3; k++) begin
            MOTION_DETECT_N_IN <= 1'b0;
            wait_state(2'd3);
            MOTION_DETECT_N_IN <= 1'b1;
            over_on <= (k == 0);
            LEVEL_IN <= (k == 1) ? 12'h010 : 12'h200;
            cur_on <= (k != 2);
            wait_state(2'd0);
            rc("event", REG_EVENT, 32'h1 << ((k == 2) ? 1 : k + 2));
            wr(REG_EVENT, 32'h1f);
            over_on <= 1'b0;
            LEVEL_IN <= 12'h200;
            cur_on <= 1'b1;
        end
        test_done();
    end
endmodule // testbench
`default_nettype wire
